//--- rbms_pkg.sv
// Package for the reset boot mode sequencer: modes, addresses, timing, header fields.
// Assumes a single system clock domain; no bus, all controls are plain ports.
package rbms_pkg;
	// ****************************************
	// Boot modes
	// ****************************************
	typedef enum logic [1:0] {
		RBMS_MODE_DIRECT = 2'h0,   // Execute from 16-bit external memory
		RBMS_MODE_FLASH  = 2'h1,   // Load from parallel flash
		RBMS_MODE_HOST   = 2'h2,   // Load as SPI slave from a host
		RBMS_MODE_EEPROM = 2'h3    // Load as SPI master from serial EEPROM
	} rbms_mode_e;

	// ****************************************
	// Addresses
	// ****************************************
	localparam logic [31:0] RBMS_ADDR_EXT_START = 32'h2000_0000; // Direct execution start
	localparam logic [31:0] RBMS_ADDR_L1_START  = 32'hFFA0_0000; // First core L1 start
	localparam logic [31:0] RBMS_ADDR_B_START   = 32'hFF60_0000; // Second core start
	localparam logic [23:0] RBMS_EE_START_ADDR  = 24'h00_0000;   // EEPROM read start
	localparam logic [7:0]  RBMS_EE_READ_CMD    = 8'h03;         // Serial memory read opcode

	// ****************************************
	// Asynchronous memory default timing
	// ****************************************
	localparam logic [1:0] RBMS_AMEM_HOLD   = 2'h3; // Hold cycles
	localparam logic [3:0] RBMS_AMEM_ACCESS = 4'hF; // Read/write access cycles
	localparam logic [2:0] RBMS_AMEM_SETUP  = 3'h4; // Setup cycles
	localparam logic [1:0] RBMS_FLASH_BANK  = 2'h0; // Bank used by flash boot

	// ****************************************
	// Field positions
	// ****************************************
	localparam int RBMS_HOLD_SEL_LSB   = 5;  // Hold flag select, low bit in header
	localparam int RBMS_HOLD_SEL_MSB   = 10; // Hold flag select, high bit in header
	localparam int RBMS_SYSCFG_B_HOLD  = 5;  // Second core hold bit
	localparam int RBMS_RSTCFG_NOBOOT  = 4;  // Skip boot on software reset
	localparam int RBMS_HDR_FINAL      = 15; // Header flag: last block
	localparam int RBMS_HDR_NOLOAD     = 8;  // Header flag: fill/ no payload
	localparam int RBMS_HDR_BYTES      = 10; // Block header length in bytes
endpackage

//--- rbms_spi_byte.sv
// Byte shifter for the serial link, as master or slave, SPI mode 0, MSB first.
// Assumes the link pins arrive raw; they are synchronised here on the system clock.
module rbms_spi_byte
	import rbms_pkg::*;
#(
	parameter int DIV = 4 // System clocks per half link clock when master
) (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       nrst,
	// Control
	input  wire logic       master,    // 1: drive the link clock
	input  wire logic       start,     // Master: begin one byte
	input  wire logic [7:0] tx_byte,   // Master: byte to send
	// Link pins
	input  wire logic       sck_in,    // Link clock from host
	input  wire logic       miso_mosi, // Serial data in
	output logic            sck_out,   // Link clock when master
	output logic            sdo,       // Serial data out
	// Result
	output logic            done,      // One-cycle pulse per byte
	output logic [7:0]      rx_byte    // Received byte
);
	// ****************************************
	// State
	// ****************************************
	logic [1:0] sck_sync_r, din_sync_r;   // Two-stage synchronisers
	logic       sck_d_r, sck_d_nxt;       // Last synced link clock
	logic [7:0] sh_r, sh_nxt;             // Receive shifter
	logic [7:0] tx_r, tx_nxt;             // Transmit shifter
	logic [2:0] cnt_r, cnt_nxt;           // Bit count
	logic [7:0] div_r, div_nxt;           // Half period counter
	logic       busy_r, busy_nxt;         // Master byte in flight
	logic       sck_r, sck_nxt;           // Generated link clock
	logic       done_r, done_nxt;         // Byte complete
	logic       pend_r, pend_nxt;         // Start waiting for the shifter to free up
	logic [7:0] rx_r, rx_nxt;             // Captured byte
	logic       rise, fall;               // Link clock edges

	assign sck_out = sck_r;
	assign sdo     = tx_r[7];
	assign done    = done_r;
	assign rx_byte = rx_r;

	// Edges of whichever clock is in use
	always_comb begin
		rise = master ? (busy_r && !sck_r && div_r == 8'(DIV - 1)) : (sck_sync_r[1] && !sck_d_r);
		fall = master ? (busy_r &&  sck_r && div_r == 8'(DIV - 1)) : (!sck_sync_r[1] && sck_d_r);
	end

	// Next state
	always_comb begin
		sck_d_nxt = sck_sync_r[1];
		sh_nxt    = sh_r;
		tx_nxt    = tx_r;
		cnt_nxt   = cnt_r;
		div_nxt   = busy_r ? ((div_r == 8'(DIV - 1)) ? 8'h00 : div_r + 8'h01) : 8'h00;
		busy_nxt  = busy_r;
		sck_nxt   = sck_r;
		done_nxt  = 1'b0;
		rx_nxt    = rx_r;
		pend_nxt  = pend_r;
		if (master && (start || pend_r) && !busy_r) begin
			// Load a byte to send
			busy_nxt = 1'b1;
			tx_nxt   = tx_byte;
			cnt_nxt  = 3'h0;
			pend_nxt = 1'b0;
		end else if (master && start) begin
			// Done comes before the last falling edge: keep the start until the shifter is free
			pend_nxt = 1'b1;
		end
		if (rise) begin
			// Sample on rising edge
			sh_nxt = {sh_r[6:0], din_sync_r[1]};
			if (master) sck_nxt = 1'b1;
			if (cnt_r == 3'h7) begin
				done_nxt = 1'b1;
				rx_nxt   = {sh_r[6:0], din_sync_r[1]};
			end
		end
		if (fall) begin
			// Shift out on falling edge
			tx_nxt  = {tx_r[6:0], 1'b0};
			cnt_nxt = cnt_r + 3'h1;
			if (master) begin
				sck_nxt = 1'b0;
				if (cnt_r == 3'h7) busy_nxt = 1'b0;
			end
		end
	end

	// Registers
	always_ff @(posedge clk) begin
		sck_sync_r <= {sck_sync_r[0], sck_in};
		din_sync_r <= {din_sync_r[0], miso_mosi};
		if (!nrst) begin
			sck_d_r <= 1'b0;
			sh_r    <= 8'h00;
			tx_r    <= 8'h00;
			cnt_r   <= 3'h0;
			div_r   <= 8'h00;
			busy_r  <= 1'b0;
			sck_r   <= 1'b0;
			done_r  <= 1'b0;
			rx_r    <= 8'h00;
			pend_r  <= 1'b0;
		end else begin
			sck_d_r <= sck_d_nxt;
			sh_r    <= sh_nxt;
			tx_r    <= tx_nxt;
			cnt_r   <= cnt_nxt;
			div_r   <= div_nxt;
			busy_r  <= busy_nxt;
			sck_r   <= sck_nxt;
			done_r  <= done_nxt;
			rx_r    <= rx_nxt;
			pend_r  <= pend_nxt;
		end
	end
endmodule

//--- rbms_top.sv
// Reset boot mode sequencer: picks the boot action, loads blocks, releases the cores.
// Assumes REF_CLK is the system clock; pins are raw and synchronised here.
module rbms_top
	import rbms_pkg::*;
#(
	parameter int EE_ADDR_BYTES = 3, // EEPROM address bytes, 2 or 3
	parameter int SPI_DIV       = 4  // System clocks per half link clock
) (
	// Clock and reset
	input  wire logic        REF_CLK,
	input  wire logic        NRST,
	// Reset cause and configuration
	input  wire logic [1:0]  BOOT_MODE_PINS,
	input  wire logic        SOFT_RESET,        // Reset came from software
	input  wire logic        CORE_POWERED_DOWN, // Core supply off (hibernate)
	input  wire logic        RESET_NO_BOOT,     // Reset configuration bit 4
	input  wire logic [15:0] CORE_A_SYSTEM_CONFIG,
	// Parallel flash byte stream (from memory controller)
	input  wire logic        FLASH_VALID,
	input  wire logic [7:0]  FLASH_DATA,
	output logic             FLASH_REQ,
	// Serial link
	input  wire logic        SPI_SCK_IN,
	input  wire logic        SPI_DIN,
	output logic             SPI_SCK_OUT,
	output logic             SPI_SCK_OE_N,
	output logic             SPI_DOUT,
	output logic             EEPROM_SELECT_PIN_N,
	// Host hold flag, three-state style per flag
	output logic [63:0]      HOST_HOLD_FLAG,
	output logic [63:0]      HOST_HOLD_FLAG_OE_N,
	// Memory write port for loaded blocks
	output logic             MEM_WE,
	output logic [31:0]      MEM_ADDR,
	output logic [7:0]       MEM_DATA,
	// Boot results
	output logic [1:0]       BOOT_MODE_STATUS,
	output logic             REGULATOR_ON,
	output logic             AMEM_BANK0_EN,
	output logic [1:0]       AMEM_HOLD,
	output logic [3:0]       AMEM_ACCESS,
	output logic [2:0]       AMEM_SETUP,
	output logic             AMEM_PACK16,
	output logic             CORE_B_EXT_FETCH_EN,
	output logic             CORE_A_RUN,
	output logic [31:0]      CORE_A_PC,
	output logic             CORE_B_RUN,
	output logic [31:0]      CORE_B_PC
);
	// ****************************************
	// Types and state
	// ****************************************
	typedef enum logic [3:0] {
		S_WAKE, S_DECIDE, S_EE_CMD, S_HDR, S_DATA, S_DONE
	} rbms_state_e;

	rbms_state_e state_r, state_nxt;     // Sequencer state
	rbms_mode_e  mode_r, mode_nxt;       // Captured boot mode
	logic [1:0]  pin_sync_r;             // Pin synchroniser stage 1
	logic [1:0]  pin_s2_r;               // Pin synchroniser stage 2
	logic [79:0] hdr_r, hdr_nxt;         // Block header bytes
	logic [3:0]  hcnt_r, hcnt_nxt;       // Header byte count
	logic [31:0] addr_r, addr_nxt;       // Block destination
	logic [31:0] left_r, left_nxt;       // Bytes left in block
	logic [2:0]  ecnt_r, ecnt_nxt;       // EEPROM command bytes sent
	logic [5:0]  hsel_r, hsel_nxt;       // Hold flag select
	logic        final_r, final_nxt;     // Current block is last
	logic        a_run_r, a_run_nxt;     // First core running
	logic [31:0] a_pc_r, a_pc_nxt;       // First core start
	logic        b_run_r, b_run_nxt;     // Second core released
	logic        we_r, we_nxt;           // Write strobe
	logic [31:0] waddr_r, waddr_nxt;     // Write address
	logic [7:0]  wdata_r, wdata_nxt;     // Write data
	logic        start_r, start_nxt;     // Master byte start
	logic [7:0]  txb_r, txb_nxt;         // Master byte
	logic        spi_done;               // Byte from link
	logic [7:0]  spi_byte;               // Its value
	logic        in_valid;               // Source picked by the mode has a byte
	logic [7:0]  in_byte;                // That byte
	logic        serial;                 // Serial modes

	// ****************************************
	// Serial byte engine
	// ****************************************
	assign serial = (mode_r == RBMS_MODE_HOST) || (mode_r == RBMS_MODE_EEPROM);

	rbms_spi_byte #(.DIV(SPI_DIV)) u_spi (
		.clk      (REF_CLK),
		.nrst     (NRST),
		.master   (mode_r == RBMS_MODE_EEPROM),
		.start    (start_r),
		.tx_byte  (txb_r),
		.sck_in   (SPI_SCK_IN),
		.miso_mosi(SPI_DIN),
		.sck_out  (SPI_SCK_OUT),
		.sdo      (SPI_DOUT),
		.done     (spi_done),
		.rx_byte  (spi_byte)
	);

	// Byte source for the loader
	always_comb begin
		in_valid = serial ? spi_done : (FLASH_VALID && FLASH_REQ);
		in_byte  = serial ? spi_byte : FLASH_DATA;
	end

	// ****************************************
	// Fixed and derived outputs
	// ****************************************
	assign BOOT_MODE_STATUS    = mode_r;
	assign REGULATOR_ON        = (state_r != S_WAKE);
	assign AMEM_BANK0_EN       = (mode_r == RBMS_MODE_FLASH) || (mode_r == RBMS_MODE_DIRECT);
	assign AMEM_HOLD           = RBMS_AMEM_HOLD;
	assign AMEM_ACCESS         = RBMS_AMEM_ACCESS;
	assign AMEM_SETUP          = RBMS_AMEM_SETUP;
	assign AMEM_PACK16         = (mode_r == RBMS_MODE_DIRECT);
	assign CORE_B_EXT_FETCH_EN = (mode_r != RBMS_MODE_DIRECT);
	assign SPI_SCK_OE_N        = (mode_r != RBMS_MODE_EEPROM);
	assign EEPROM_SELECT_PIN_N = !((mode_r == RBMS_MODE_EEPROM) &&
	                               (state_r == S_EE_CMD || state_r == S_HDR || state_r == S_DATA));
	assign FLASH_REQ           = (mode_r == RBMS_MODE_FLASH) && (state_r == S_HDR || state_r == S_DATA);
	assign MEM_WE              = we_r;
	assign MEM_ADDR            = waddr_r;
	assign MEM_DATA            = wdata_r;
	assign CORE_A_RUN          = a_run_r;
	assign CORE_A_PC           = a_pc_r;
	assign CORE_B_RUN          = b_run_r;
	assign CORE_B_PC           = RBMS_ADDR_B_START;

	// Hold flag: selected flag driven high while loader busy, others released
	always_comb begin
		HOST_HOLD_FLAG      = 64'h0;
		HOST_HOLD_FLAG_OE_N = {64{1'b1}};
		if (mode_r == RBMS_MODE_HOST && !a_run_r) begin
			HOST_HOLD_FLAG_OE_N[hsel_r] = 1'b0;
			HOST_HOLD_FLAG[hsel_r]      = (state_r != S_HDR && state_r != S_DATA) || we_r;
		end
	end

	// ****************************************
	// Sequencer next state
	// ****************************************
	always_comb begin
		state_nxt = state_r;
		mode_nxt  = mode_r;
		hdr_nxt   = hdr_r;
		hcnt_nxt  = hcnt_r;
		addr_nxt  = addr_r;
		left_nxt  = left_r;
		ecnt_nxt  = ecnt_r;
		hsel_nxt  = hsel_r;
		final_nxt = final_r;
		a_run_nxt = a_run_r;
		a_pc_nxt  = a_pc_r;
		b_run_nxt = b_run_r;
		we_nxt    = 1'b0;
		waddr_nxt = waddr_r;
		wdata_nxt = wdata_r;
		start_nxt = 1'b0;
		txb_nxt   = txb_r;
		unique case (state_r)
			S_WAKE: begin
				// Regulator comes back, then boot proceeds
				state_nxt = S_DECIDE;
			end
			S_DECIDE: begin
				mode_nxt = rbms_mode_e'(pin_s2_r);
				if (SOFT_RESET && RESET_NO_BOOT) begin
					a_pc_nxt  = RBMS_ADDR_L1_START;
					a_run_nxt = 1'b1;
					state_nxt = S_DONE;
				end else if (rbms_mode_e'(pin_s2_r) == RBMS_MODE_DIRECT) begin
					a_pc_nxt  = RBMS_ADDR_EXT_START;
					a_run_nxt = 1'b1;
					state_nxt = S_DONE;
				end else if (rbms_mode_e'(pin_s2_r) == RBMS_MODE_EEPROM) begin
					ecnt_nxt  = 3'h0;
					state_nxt = S_EE_CMD;
				end else begin
					hcnt_nxt  = 4'h0;
					state_nxt = S_HDR;
				end
			end
			S_EE_CMD: begin
				// Read opcode then start address, MSB first
				if (ecnt_r == 3'h0 && !start_r) begin
					txb_nxt   = RBMS_EE_READ_CMD;
					start_nxt = 1'b1;
					ecnt_nxt  = 3'h1;
				end else if (spi_done) begin
					if (ecnt_r == 3'(EE_ADDR_BYTES + 1)) begin
						txb_nxt   = 8'h00;
						start_nxt = 1'b1;
						hcnt_nxt  = 4'h0;
						state_nxt = S_HDR;
					end else begin
						txb_nxt   = RBMS_EE_START_ADDR[8*(EE_ADDR_BYTES-int'(ecnt_r)) +: 8];
						start_nxt = 1'b1;
						ecnt_nxt  = ecnt_r + 3'h1;
					end
				end
			end
			S_HDR: begin
				// Collect block header: address, count, flags, little endian
				if (in_valid) begin
					hdr_nxt  = {in_byte, hdr_r[79:8]};
					hcnt_nxt = hcnt_r + 4'h1;
					start_nxt = (mode_r == RBMS_MODE_EEPROM);
					if (hcnt_r == 4'(RBMS_HDR_BYTES - 1)) begin
						addr_nxt  = hdr_nxt[31:0];
						left_nxt  = hdr_nxt[63:32];
						final_nxt = hdr_nxt[64 + RBMS_HDR_FINAL];
						if (mode_r == RBMS_MODE_HOST)
							hsel_nxt = hdr_nxt[64 + RBMS_HOLD_SEL_MSB : 64 + RBMS_HOLD_SEL_LSB];
						hcnt_nxt  = 4'h0;
						if (hdr_nxt[63:32] == 32'h0 || hdr_nxt[64 + RBMS_HDR_NOLOAD])
							state_nxt = hdr_nxt[64 + RBMS_HDR_FINAL] ? S_DONE : S_HDR;
						else
							state_nxt = S_DATA;
						if ((hdr_nxt[63:32] == 32'h0 || hdr_nxt[64 + RBMS_HDR_NOLOAD]) && hdr_nxt[64 + RBMS_HDR_FINAL]) begin
							a_pc_nxt  = RBMS_ADDR_L1_START;
							a_run_nxt = 1'b1;
							start_nxt = 1'b0;
						end
					end
				end
			end
			S_DATA: begin
				// Store payload bytes at the block destination
				if (in_valid) begin
					we_nxt    = 1'b1;
					waddr_nxt = addr_r;
					wdata_nxt = in_byte;
					addr_nxt  = addr_r + 32'h1;
					left_nxt  = left_r - 32'h1;
					start_nxt = (mode_r == RBMS_MODE_EEPROM);
					if (left_r == 32'h1) begin
						state_nxt = final_r ? S_DONE : S_HDR;
						if (final_r) begin
							a_pc_nxt  = RBMS_ADDR_L1_START;
							a_run_nxt = 1'b1;
							start_nxt = 1'b0;
						end
					end
				end
			end
			S_DONE: begin
				// Second core waits for the first to clear its hold bit
				if (a_run_r && !CORE_A_SYSTEM_CONFIG[RBMS_SYSCFG_B_HOLD])
					b_run_nxt = 1'b1;
			end
			default: state_nxt = S_WAKE;
		endcase
	end

	// ****************************************
	// Registers
	// ****************************************
	always_ff @(posedge REF_CLK) begin
		pin_sync_r <= BOOT_MODE_PINS;
		pin_s2_r   <= pin_sync_r;
		if (!NRST) begin
			state_r <= CORE_POWERED_DOWN ? S_WAKE : S_DECIDE;
			mode_r  <= mode_r;
			hdr_r   <= 80'h0;
			hcnt_r  <= 4'h0;
			addr_r  <= 32'h0;
			left_r  <= 32'h0;
			ecnt_r  <= 3'h0;
			hsel_r  <= 6'h0;
			final_r <= 1'b0;
			a_run_r <= 1'b0;
			a_pc_r  <= RBMS_ADDR_L1_START;
			b_run_r <= 1'b0;
			we_r    <= 1'b0;
			waddr_r <= 32'h0;
			wdata_r <= 8'h00;
			start_r <= 1'b0;
			txb_r   <= 8'h00;
		end else begin
			state_r <= state_nxt;
			mode_r  <= mode_nxt;
			hdr_r   <= hdr_nxt;
			hcnt_r  <= hcnt_nxt;
			addr_r  <= addr_nxt;
			left_r  <= left_nxt;
			ecnt_r  <= ecnt_nxt;
			hsel_r  <= hsel_nxt;
			final_r <= final_nxt;
			a_run_r <= a_run_nxt;
			a_pc_r  <= a_pc_nxt;
			b_run_r <= b_run_nxt;
			we_r    <= we_nxt;
			waddr_r <= waddr_nxt;
			wdata_r <= wdata_nxt;
			start_r <= start_nxt;
			txb_r   <= txb_nxt;
		end
	end
endmodule

//--- rbms_properties.sv
// Checker for the boot sequencer: port-level relations over time.
// Assumes it is bound to rbms_top and sees only that module's ports.
module rbms_properties
	import rbms_pkg::*;
(
	// Clock and reset
	input wire logic        REF_CLK,
	input wire logic        NRST,
	// Inputs watched
	input wire logic        RESET_NO_BOOT,
	input wire logic [15:0] CORE_A_SYSTEM_CONFIG,
	// Outputs watched
	input wire logic        FLASH_REQ,
	input wire logic        SPI_SCK_OE_N,
	input wire logic        EEPROM_SELECT_PIN_N,
	input wire logic [63:0] HOST_HOLD_FLAG_OE_N,
	input wire logic [1:0]  BOOT_MODE_STATUS,
	input wire logic        REGULATOR_ON,
	input wire logic        AMEM_BANK0_EN,
	input wire logic [1:0]  AMEM_HOLD,
	input wire logic [3:0]  AMEM_ACCESS,
	input wire logic [2:0]  AMEM_SETUP,
	input wire logic        AMEM_PACK16,
	input wire logic        CORE_B_EXT_FETCH_EN,
	input wire logic        CORE_A_RUN,
	input wire logic [31:0] CORE_A_PC,
	input wire logic        CORE_B_RUN,
	input wire logic [31:0] CORE_B_PC
);
	// ****************************************
	// Sequences
	// ****************************************
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (!NRST);
	// Regulator off for exactly one cycle, then back on
	sequence s_wake;
		!REGULATOR_ON ##1 REGULATOR_ON;
	endsequence
	// Second core starts only beside a running first core
	sequence s_b_start;
		$past(CORE_A_RUN) && !$past(CORE_A_SYSTEM_CONFIG[RBMS_SYSCFG_B_HOLD]) && CORE_B_PC == RBMS_ADDR_B_START;
	endsequence

	// ****************************************
	// Assertions
	// ****************************************
	a_direct_fetch: assert property (CORE_A_RUN && BOOT_MODE_STATUS == RBMS_MODE_DIRECT && !RESET_NO_BOOT
		|-> CORE_A_PC == RBMS_ADDR_EXT_START && AMEM_PACK16) else $error("direct start wrong");
	a_loaded_start: assert property (CORE_A_RUN && BOOT_MODE_STATUS != RBMS_MODE_DIRECT
		|-> CORE_A_PC == RBMS_ADDR_L1_START) else $error("loaded start wrong");
	a_slow_timing: assert property (AMEM_HOLD == RBMS_AMEM_HOLD && AMEM_ACCESS == RBMS_AMEM_ACCESS
		&& AMEM_SETUP == RBMS_AMEM_SETUP) else $error("memory timing wrong");
	a_core_b_local: assert property (BOOT_MODE_STATUS == RBMS_MODE_DIRECT |-> !CORE_B_EXT_FETCH_EN)
		else $error("second core fetches externally");
	a_bank_zero: assert property (FLASH_REQ |-> AMEM_BANK0_EN) else $error("flash without bank 0");
	a_hold_host: assert property (HOST_HOLD_FLAG_OE_N != '1
		|-> BOOT_MODE_STATUS == RBMS_MODE_HOST && !CORE_A_RUN) else $error("hold flag out of host load");
	a_ee_master: assert property (!EEPROM_SELECT_PIN_N
		|-> BOOT_MODE_STATUS == RBMS_MODE_EEPROM && !SPI_SCK_OE_N) else $error("select outside master load");
	a_b_held: assert property (CORE_A_SYSTEM_CONFIG[RBMS_SYSCFG_B_HOLD] && !CORE_B_RUN |=> !CORE_B_RUN)
		else $error("second core left hold");
	a_b_release: assert property ($rose(CORE_B_RUN) |-> s_b_start) else $error("second core start wrong");
	a_b_level: assert property (CORE_B_RUN |=> CORE_B_RUN) else $error("second core release dropped");
	a_reset_clear: assert property (disable iff (1'b0) !NRST |=> !CORE_A_RUN && !CORE_B_RUN)
		else $error("reset left a core running");
	a_wake_pulse: assert property (NRST && !REGULATOR_ON |-> s_wake) else $error("regulator off too long");
	a_mode_kept: assert property (CORE_A_RUN |=> $stable(BOOT_MODE_STATUS)) else $error("mode changed");
endmodule

bind rbms_top rbms_properties rbms_properties_i (.REF_CLK, .NRST, .RESET_NO_BOOT, .CORE_A_SYSTEM_CONFIG,
	.FLASH_REQ, .SPI_SCK_OE_N, .EEPROM_SELECT_PIN_N, .HOST_HOLD_FLAG_OE_N, .BOOT_MODE_STATUS,
	.REGULATOR_ON, .AMEM_BANK0_EN, .AMEM_HOLD, .AMEM_ACCESS, .AMEM_SETUP, .AMEM_PACK16,
	.CORE_B_EXT_FETCH_EN, .CORE_A_RUN, .CORE_A_PC, .CORE_B_RUN, .CORE_B_PC);

//--- rbms_host_model.sv
// Host master on the serial link, mode 0, MSB first, 32 ns link clock.
// Assumes the bench hands it the hold flag that the header selects.
module rbms_host_model (
	// Link pins
	output logic      sck,  // Link clock, low between bytes
	output logic      din,  // Serial data to the device
	// Flow control
	input  wire logic hold  // High while the device is busy
);
	timeunit 1ns;
	timeprecision 1ps;
	// Link idle at time zero
	initial begin
		sck = 1'b0;
		din = 1'b0;
	end
	// Send one byte as master, after the device lets go of hold
	task automatic send_byte(input logic [7:0] b);
		int i;
		while (hold === 1'b1) #32;
		// Step off the system clock edge so the pins never change on it
		#1;
		for (i = 7; i >= 0; i--) begin
			din = b[i];
			#16 sck = 1'b1;
			#16 sck = 1'b0;
		end
		// Released line must not keep the last bit
		din = ~b[0];
		#63;
	endtask
endmodule

//--- rbms_top_tb_top.sv
// Bench for the boot sequencer: runs every boot mode and checks ports.
// Assumes rbms_top, the host model and the bound checker are compiled.
module rbms_top_tb_top
	import rbms_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	// Stimulus
	logic        ref_clk = 1'b0, nrst = 1'b0, soft_rst = 1'b0, pwr_down = 1'b0, no_boot = 1'b0;
	logic [1:0]  mode_pins = 2'h0;
	logic [15:0] cfg = 16'h0000;
	logic        flash_valid = 1'b0, src = 1'b0;
	logic [7:0]  flash_data = 8'h00;
	// Observed
	logic        flash_req, sck_in, din, sck_out, sck_oe_n, dout, ee_sel_n, mem_we, reg_on, bank0;
	logic        pack16, b_fetch, a_run, b_run, sck_d, saw_reg_off, saw_hold_oe, saw_hold_hi;
	logic [63:0] hold, hold_oe_n;
	logic [31:0] mem_addr, a_pc, b_pc, bits;
	logic [7:0]  mem_data;
	logic [1:0]  mode_st;
	logic [39:0] wq[$], eq[$];
	int          n_fail = 0, check_count = 0, i, n;

	always #2 ref_clk = ~ref_clk;

	rbms_top rbms_top_i (.REF_CLK(ref_clk), .NRST(nrst), .BOOT_MODE_PINS(mode_pins), .SOFT_RESET(soft_rst),
		.CORE_POWERED_DOWN(pwr_down), .RESET_NO_BOOT(no_boot), .CORE_A_SYSTEM_CONFIG(cfg),
		.FLASH_VALID(flash_valid), .FLASH_DATA(flash_data), .FLASH_REQ(flash_req), .SPI_SCK_IN(sck_in),
		.SPI_DIN(din), .SPI_SCK_OUT(sck_out), .SPI_SCK_OE_N(sck_oe_n), .SPI_DOUT(dout),
		.EEPROM_SELECT_PIN_N(ee_sel_n), .HOST_HOLD_FLAG(hold), .HOST_HOLD_FLAG_OE_N(hold_oe_n),
		.MEM_WE(mem_we), .MEM_ADDR(mem_addr), .MEM_DATA(mem_data), .BOOT_MODE_STATUS(mode_st),
		.REGULATOR_ON(reg_on), .AMEM_BANK0_EN(bank0), .AMEM_HOLD(), .AMEM_ACCESS(), .AMEM_SETUP(),
		.AMEM_PACK16(pack16), .CORE_B_EXT_FETCH_EN(b_fetch), .CORE_A_RUN(a_run), .CORE_A_PC(a_pc),
		.CORE_B_RUN(b_run), .CORE_B_PC(b_pc));
	rbms_host_model rbms_host_model_i (.sck(sck_in), .din(din), .hold(hold[3] & ~hold_oe_n[3]));

	// Record memory writes and one-off events
	always @(posedge ref_clk) begin
		sck_d <= sck_out;
		if (mem_we === 1'b1) wq.push_back({mem_addr, mem_data});
		if (reg_on === 1'b0 && nrst) saw_reg_off <= 1'b1;
		if (hold_oe_n[3] === 1'b0) saw_hold_oe <= 1'b1;
		if (hold[3] === 1'b1) saw_hold_hi <= 1'b1;
	end

	// Compare and count
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask
	// Reset with the given causes; pins held steady through it
	task automatic do_reset(input logic [1:0] m, input logic s, input logic nb, input logic pd);
		@(posedge ref_clk);
		nrst <= 1'b0; mode_pins <= m; soft_rst <= s; no_boot <= nb; pwr_down <= pd;
		repeat (3) @(posedge ref_clk);
		chk("core a run in reset", 0, a_run);
		chk("core b run in reset", 0, b_run);
		wq.delete(); eq.delete();
		nrst <= 1'b1; saw_reg_off <= 1'b0; saw_hold_oe <= 1'b0; saw_hold_hi <= 1'b0;
		@(posedge ref_clk) pwr_down <= 1'b0;
		repeat (4) @(posedge ref_clk);
		chk("mode status", m, mode_st);
	endtask
	// One flash byte, held until the loader takes it
	task automatic flash_byte(input logic [7:0] b);
		flash_valid <= 1'b1; flash_data <= b; n = 0;
		do begin @(posedge ref_clk); n++; end while (flash_req !== 1'b1 && n < 1000);
	endtask
	task automatic put_byte(input logic [7:0] b);
		if (src) rbms_host_model_i.send_byte(b);
		else flash_byte(b);
	endtask
	// Header little endian, then payload to consecutive places
	task automatic send_block(input logic [31:0] a, input logic [31:0] c, input logic [15:0] f);
		logic [79:0] h;
		h = {f, c, a};
		for (i = 0; i < 10; i++) put_byte(h[8*i +: 8]);
		for (i = 0; i < c; i++) begin
			put_byte(8'(8'hA0 + i));
			eq.push_back({a + 32'(i), 8'(8'hA0 + i)});
		end
	endtask
	// Stop the flash stream and wait for the first core
	task automatic wait_run;
		flash_valid <= 1'b0; n = 0;
		while (a_run !== 1'b1 && n < 2000) begin @(posedge ref_clk); n++; end
		// Let the last write reach the recorder before the queues are read
		repeat (2) @(posedge ref_clk);
		chk("core a run", 1, a_run);
		chk("write count", eq.size(), wq.size());
		for (i = 0; i < eq.size() && i < wq.size(); i++) begin
			chk("write address", eq[i][39:8], wq[i][39:8]);
			chk("write data", 32'(eq[i][7:0]), 32'(wq[i][7:0]));
		end
	endtask
	task automatic final_report;
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask

	// Watchdog
	initial begin
		#300000;
		n_fail++;
		final_report;
	end

	// ****************************************
	// Tests
	// ****************************************
	initial begin
		// Wake from hibernate, two flash blocks
		do_reset(RBMS_MODE_FLASH, 1'b0, 1'b0, 1'b1);
		send_block(32'hFFA0_0010, 32'h2, 16'h0000);
		send_block(32'hFF80_0100, 32'h1, 16'h8000);
		wait_run();
		chk("regulator off seen", 1, saw_reg_off);
		chk("bank 0", 1, bank0);
		$display("test flash done");
		// Software reset that skips the load
		do_reset(RBMS_MODE_FLASH, 1'b1, 1'b1, 1'b0);
		wait_run();
		chk("skip boot pc", RBMS_ADDR_L1_START, a_pc);
		$display("test skip boot done");
		// Direct mode, second core held then released
		cfg <= 16'h0020;
		do_reset(RBMS_MODE_DIRECT, 1'b1, 1'b0, 1'b0);
		wait_run();
		chk("direct pc", RBMS_ADDR_EXT_START, a_pc);
		chk("pack16", 1, pack16);
		chk("core b ext fetch", 0, b_fetch);
		repeat (8) @(posedge ref_clk);
		chk("core b held", 0, b_run);
		cfg <= 16'h0000; n = 0;
		while (b_run !== 1'b1 && n < 100) begin @(posedge ref_clk); n++; end
		chk("core b pc", RBMS_ADDR_B_START, b_pc);
		repeat (8) @(posedge ref_clk);
		chk("core b level", 1, b_run);
		$display("test direct done");
		// Host load, hold flag 3 chosen in the header
		src = 1'b1;
		do_reset(RBMS_MODE_HOST, 1'b0, 1'b0, 1'b0);
		send_block(32'hFFA0_0020, 32'h2, 16'h8060);
		wait_run();
		chk("hold flag driven", 1, saw_hold_oe);
		chk("hold flag raised", 1, saw_hold_hi);
		$display("test host done");
		// Serial memory: command and start address
		do_reset(RBMS_MODE_EEPROM, 1'b0, 1'b0, 1'b0);
		n = 0;
		while (ee_sel_n !== 1'b0 && n < 1000) begin @(posedge ref_clk); n++; end
		for (i = 31; i >= 0; i--) begin
			do @(posedge ref_clk); while (!(sck_out === 1'b1 && sck_d === 1'b0));
			bits[i] = dout;
		end
		chk("read command", {RBMS_EE_READ_CMD, RBMS_EE_START_ADDR}, bits);
		chk("link clock driven", 0, sck_oe_n);
		$display("test eeprom done");
		final_report;
	end
endmodule
